// ---- hdl/dus_seq.sv ----
// Purpose: busy / load / clear / reset sequencing of a multichannel dac
// Assumes: all pins asynchronous to CLK; serial clock sampled by CLK
// Notes:   frame decode and transfer arithmetic live outside this block
`timescale 1ns/1ps
`include "dus_cfg.svh"

module dus_seq (
    input  wire logic         CLK,
    input  wire logic         RST_B,
    input  wire logic         RESET_PIN_B,
    input  wire logic         LOAD_OUTPUTS_N,
    input  wire logic         CLEAR_TO_CODE_N,
    input  wire logic         POWER_DOWN_IN,
    input  wire logic         FIFO_EN_IN,
    input  wire logic         INTERFACE_SELECT,
    input  wire logic         DATA_BIT_NINE,
    input  wire logic         DATA_BIT_TEN,
    input  wire logic         DATA_BIT_ELEVEN_IN,
    input  wire logic         WRITE_STROBE_N,
    input  wire logic         CHIP_SELECT_N,
    input  wire logic         PD_HIGH_Z_CFG,
    input  wire logic         ACK_PULL,
    output logic              DATA_BIT_ELEVEN_OUT,
    output logic              DATA_BIT_ELEVEN_OE,
    output logic              BUSY_N,
    output logic              HOST_IF_EN,
    output logic              REG_WRITE,
    output logic              DAC_LOAD_ALL,
    output logic              DAC_LOAD_CLEAR,
    output logic              DEFAULTS_LOAD,
    output logic              ANALOG_LOW_POWER,
    output logic              OUT_HIGH_Z,
    output logic              OUT_PULLDOWN,
    output logic              SERIAL_MODE,
    output logic              I2C_MODE,
    output logic              FIFO_ON,
    output logic [`DUS_SHIFT_W-1:0] SHIFT_WORD
);

    localparam logic [`DUS_CNT_W-1:0] CLEAR_CNT = `DUS_CNT_W'(`DUS_CLEAR_CYCLES);
    localparam logic [`DUS_CNT_W-1:0] RESET_CNT = `DUS_CNT_W'(`DUS_RESET_CYCLES);
    localparam logic [`DUS_CNT_W-1:0] CALC_CNT  = `DUS_CNT_W'(`DUS_CALC_CYCLES);
    localparam logic [`DUS_CNT_W-1:0] XFER_CNT  = `DUS_CNT_W'(`DUS_XFER_CYCLES);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: first stage feeds only the second
    logic [10:0] sync1_r;
    logic [10:0] sync2_r;
    logic [10:0] prev_r;
    logic [10:0] pins;

    assign pins = {INTERFACE_SELECT, DATA_BIT_NINE, RESET_PIN_B, LOAD_OUTPUTS_N,
                   CLEAR_TO_CODE_N, POWER_DOWN_IN, DATA_BIT_TEN, DATA_BIT_ELEVEN_IN,
                   WRITE_STROBE_N, CHIP_SELECT_N, FIFO_EN_IN};

    // two-flop synchroniser plus edge history; reset to idle pin levels so
    // that no false edge or power-down blip follows reset
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            sync1_r <= 11'h1df;
            sync2_r <= 11'h1df;
            prev_r  <= 11'h1df;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    function automatic logic fell(input logic now_v, input logic was_v);
        fell = was_v & ~now_v;
    endfunction

    logic rst_fall;
    logic ld_fall;
    logic clr_fall;
    logic sclk_fall;
    logic wr_rise;
    assign rst_fall  = fell(sync2_r[8], prev_r[8]);
    assign ld_fall   = fell(sync2_r[7], prev_r[7]);
    assign clr_fall  = fell(sync2_r[6], prev_r[6]);
    assign sclk_fall = fell(sync2_r[4], prev_r[4]);
    assign wr_rise   = fell(prev_r[2], sync2_r[2]);

    ////////////////////////////////////////////////////////////////////////////
    // sequencer state
    dus_pkg::dus_state_t state_r;
    dus_pkg::dus_state_t state_nxt;
    logic [`DUS_CNT_W-1:0] cnt_r;
    logic                  ld_pend_r;
    logic                  spi_done_r;
    dus_pkg::dus_mode_t    mode_r;
    logic                  calc_req;
    logic                  cnt_done;
    logic                  idle;

    assign idle     = (state_r == dus_pkg::DUS_IDLE);
    assign cnt_done = (cnt_r == '0);

    // next state; reset has top priority, then clear, then loads, then calc
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            dus_pkg::DUS_IDLE: begin
                if (clr_fall) begin
                    state_nxt = dus_pkg::DUS_CLEAR;
                end else if (ld_fall || ld_pend_r) begin
                    state_nxt = dus_pkg::DUS_XFER;
                end else if (calc_req) begin
                    state_nxt = dus_pkg::DUS_CALC;
                end
            end
            dus_pkg::DUS_CALC,
            dus_pkg::DUS_XFER,
            dus_pkg::DUS_CLEAR,
            dus_pkg::DUS_RESET: begin
                if (cnt_done) begin
                    state_nxt = dus_pkg::DUS_IDLE;
                end
            end
            default: state_nxt = dus_pkg::DUS_RESET;
        endcase
        if (rst_fall) begin
            state_nxt = dus_pkg::DUS_RESET;
        end else if (clr_fall && state_r != dus_pkg::DUS_RESET) begin
            state_nxt = dus_pkg::DUS_CLEAR;
        end
    end

    // power-on behaves as a reset sequence
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_r <= dus_pkg::DUS_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // duration counter loaded on state entry
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cnt_r <= RESET_CNT - 1'b1;
        end else if (state_nxt != state_r) begin
            unique case (state_nxt)
                dus_pkg::DUS_CALC:  cnt_r <= CALC_CNT - 1'b1;
                dus_pkg::DUS_XFER:  cnt_r <= XFER_CNT - 1'b1;
                dus_pkg::DUS_CLEAR: cnt_r <= CLEAR_CNT - 1'b1;
                dus_pkg::DUS_RESET: cnt_r <= RESET_CNT - 1'b1;
                default:            cnt_r <= '0;
            endcase
        end else if (rst_fall || (clr_fall && state_r == dus_pkg::DUS_CLEAR)) begin
            cnt_r <= (state_r == dus_pkg::DUS_RESET) ? RESET_CNT - 1'b1 : CLEAR_CNT - 1'b1;
        end else if (!cnt_done) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    // stored load; set wins except during reset
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ld_pend_r <= 1'b0;
        end else if (state_r == dus_pkg::DUS_RESET || rst_fall) begin
            ld_pend_r <= 1'b0;
        end else if (ld_fall && (!idle || clr_fall)) begin
            ld_pend_r <= 1'b1;
        end else if (idle && state_nxt == dus_pkg::DUS_XFER) begin
            ld_pend_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // host write detection; strobe rise with select low
    // in serial mode the strobe pin has another job, so only parallel counts
    assign calc_req = (wr_rise & ~sync2_r[1] & ~mode_r.serial_mode) | spi_done_r;

    // registered outputs of the sequencer
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            BUSY_N         <= 1'b0;
            HOST_IF_EN     <= 1'b0;
            REG_WRITE      <= 1'b0;
            DAC_LOAD_ALL   <= 1'b0;
            DAC_LOAD_CLEAR <= 1'b0;
            DEFAULTS_LOAD  <= 1'b0;
        end else begin
            BUSY_N         <= (state_nxt == dus_pkg::DUS_IDLE);
            HOST_IF_EN     <= (state_nxt != dus_pkg::DUS_RESET);
            REG_WRITE      <= calc_req && state_r != dus_pkg::DUS_RESET;
            DAC_LOAD_ALL   <= (state_r == dus_pkg::DUS_XFER) && cnt_done;
            DAC_LOAD_CLEAR <= (state_r == dus_pkg::DUS_CLEAR) && cnt_done;
            DEFAULTS_LOAD  <= (state_r == dus_pkg::DUS_RESET) && cnt_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // strap sampling after power-up, clear, reset
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            mode_r <= '0;
        end else if ((state_r == dus_pkg::DUS_RESET || state_r == dus_pkg::DUS_CLEAR)
                     && cnt_done) begin
            mode_r.serial_mode <= sync2_r[10];
            mode_r.i2c_mode    <= sync2_r[10] & sync2_r[9];
            mode_r.fifo_on     <= ~sync2_r[10] & sync2_r[0];
        end
    end
    assign SERIAL_MODE = mode_r.serial_mode;
    assign I2C_MODE    = mode_r.i2c_mode;
    assign FIFO_ON     = mode_r.fifo_on;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ANALOG_LOW_POWER <= 1'b0;
            OUT_HIGH_Z       <= 1'b0;
            OUT_PULLDOWN     <= 1'b0;
        end else begin
            ANALOG_LOW_POWER <= sync2_r[5];
            OUT_HIGH_Z       <= sync2_r[5] & PD_HIGH_Z_CFG;
            OUT_PULLDOWN     <= sync2_r[5] & ~PD_HIGH_Z_CFG;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // spi shift on falling serial clock, power-down not gated
    logic [4:0] bit_cnt_r;
    logic       spi_on;
    assign spi_on = mode_r.serial_mode & ~mode_r.i2c_mode & HOST_IF_EN;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            SHIFT_WORD <= '0;
            bit_cnt_r  <= '0;
            spi_done_r <= 1'b0;
        end else begin
            spi_done_r <= 1'b0;
            if (!spi_on) begin
                bit_cnt_r <= '0;
            end else if (sclk_fall) begin
                SHIFT_WORD <= {SHIFT_WORD[`DUS_SHIFT_W-2:0], sync2_r[3]};
                if (bit_cnt_r == 5'(`DUS_SHIFT_W - 1)) begin
                    bit_cnt_r  <= '0;
                    spi_done_r <= 1'b1;
                end else begin
                    bit_cnt_r <= bit_cnt_r + 5'h1;
                end
            end
        end
    end

    // i2c data pin only pulls low, sampled at scl speed
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            DATA_BIT_ELEVEN_OE <= 1'b0;
        end else if (!mode_r.i2c_mode || sclk_fall) begin
            DATA_BIT_ELEVEN_OE <= mode_r.i2c_mode & ACK_PULL & HOST_IF_EN;
        end
    end
    assign DATA_BIT_ELEVEN_OUT = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_reset_len;
        @(posedge CLK) disable iff (!RST_B)
        rst_fall |=> !BUSY_N [*8];
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("busy rose too soon");
    property p_pend_run;
        @(posedge CLK) disable iff (!RST_B)
        (ld_pend_r && idle && !clr_fall && !rst_fall) |=> state_r == dus_pkg::DUS_XFER;
    endproperty
    a_pend_run: assert property (p_pend_run) else $error("stored load not run");
    property p_store;
        @(posedge CLK) disable iff (!RST_B)
        (ld_fall && state_r == dus_pkg::DUS_CALC && !rst_fall) |=> ld_pend_r;
    endproperty
    a_store: assert property (p_store) else $error("load not stored");
    property p_ignore;
        @(posedge CLK) disable iff (!RST_B)
        state_r == dus_pkg::DUS_RESET |=> !ld_pend_r;
    endproperty
    a_ignore: assert property (p_ignore) else $error("load kept in reset");
    property p_no_load_busy;
        @(posedge CLK) disable iff (!RST_B)
        DAC_LOAD_ALL |-> $past(state_r) == dus_pkg::DUS_XFER;
    endproperty
    a_no_load_busy: assert property (p_no_load_busy) else $error("stray dac load");

    property p_clear;
        @(posedge CLK) disable iff (!RST_B)
        (clr_fall && state_r != dus_pkg::DUS_RESET && !rst_fall) |=> !BUSY_N [*8];
    endproperty
    a_clear: assert property (p_clear) else $error("clear busy short");

    property p_open_drain;
        @(posedge CLK) disable iff (!RST_B)
        DATA_BIT_ELEVEN_OE |-> (DATA_BIT_ELEVEN_OUT == 1'b0 && I2C_MODE);
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("sda driven high");

    property p_pd;
        @(posedge CLK) disable iff (!RST_B)
        $rose(sync2_r[5]) |=> ANALOG_LOW_POWER && (OUT_HIGH_Z != OUT_PULLDOWN);
    endproperty
    a_pd: assert property (p_pd) else $error("power-down not applied");

    property p_calc;
        @(posedge CLK) disable iff (!RST_B)
        (idle && calc_req && !clr_fall && !rst_fall && !ld_fall && !ld_pend_r)
            |=> !BUSY_N [*8];
    endproperty
    a_calc: assert property (p_calc) else $error("busy not low in calc");

endmodule

// ---- hdl/dus_cfg.svh ----
// Purpose: constants for the dac update control sequencer
// Assumes: core clock of 100 MHz
// Notes:   times are kept in their own unit, clear and reset cycle counts derive from them
`ifndef DUS_CFG_SVH
`define DUS_CFG_SVH
`define DUS_CLK_MHZ        100
`define DUS_CLEAR_TIME_US  35
`define DUS_RESET_TIME_US  270
`define DUS_CLEAR_CYCLES   (`DUS_CLEAR_TIME_US * `DUS_CLK_MHZ)
`define DUS_RESET_CYCLES   (`DUS_RESET_TIME_US * `DUS_CLK_MHZ)
`define DUS_CALC_CYCLES    16
`define DUS_XFER_CYCLES    8
`define DUS_SHIFT_W        24
`define DUS_CNT_W          16
`endif

// ---- hdl/dus_pkg.sv ----
// Purpose: types for the dac update control sequencer
// Assumes: constants come from dus_cfg.svh
// Notes:   states are one-hot
package dus_pkg;
    typedef enum logic [4:0] {
        DUS_IDLE  = 5'b00001,
        DUS_CALC  = 5'b00010,
        DUS_XFER  = 5'b00100,
        DUS_CLEAR = 5'b01000,
        DUS_RESET = 5'b10000
    } dus_state_t;

    typedef struct packed {
        logic serial_mode;
        logic i2c_mode;
        logic fifo_on;
    } dus_mode_t;
endpackage

// ---- verif/dus_host_model.sv ----
// Purpose: host controller model for the dac update control sequencer
// Assumes: serial clock of 125 ns, free in phase against the core clock
// Notes:   serial clock stands high between frames
`timescale 1ns/1ps

module dus_host_model (
    input  wire logic clk,
    output logic      sclk,
    output logic      sdi,
    output logic      wr_n,
    output logic      cs_n
);
    // idle levels at time zero
    initial begin
        sclk = 1'b1;
        sdi  = 1'b1;
        wr_n = 1'b1;
        cs_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one serial bit, data set at the rise so it is steady across the fall
    // data valid at fall
    task automatic bit_out(input logic d);
        sclk = 1'b1;
        sdi  = d;
        #62.5;
        sclk = 1'b0;
        #62.5;
    endtask

    // a whole shift word, msb first; data line changes once the frame ends
    task automatic spi_word(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            bit_out(w[i]);
        end
        sclk = 1'b1;
        sdi  = ~sdi;
    endtask

    // parallel write: strobe rises with select low; select left low after
    // strobe rise select low
    task automatic pwrite();
        @(posedge clk) begin
            cs_n <= 1'b0;
            wr_n <= 1'b0;
        end
        repeat (2) @(posedge clk);
        wr_n <= 1'b1;
    endtask
endmodule

// ---- verif/testbench.sv ----
// Purpose: self-checking bench for dus_seq
// Assumes: host model supplies serial clock, data and write strobe
// Notes:   long sequence lengths allow a few cycles of pin sync delay
`timescale 1ns/1ps
`include "dus_cfg.svh"

module testbench;
    logic                    clk, rst_b, rstp_b, ld_n, clr_n, pd, fifo, isel, db9, hz, ack;
    logic                    busy_n, if_en, reg_wr, ld_all, ld_clr, dflt, lowp, hiz, pdn;
    logic                    ser, i2c, fifo_on, sda_o, sda_oe;
    logic [`DUS_SHIFT_W-1:0] sword;
    wire                     sclk, sdi, wr_n, cs_n;
    // open drain: device only pulls low, otherwise the host level on sdi
    wire                     sda = sda_oe ? 1'b0 : sdi;
    wire  [4:0]              mon = {dflt, ld_clr, reg_wr, ld_all, busy_n};
    int                      err_count, tests_run, n, lc, cc, t0, k;
    localparam int           RC = `DUS_RESET_CYCLES;
    localparam int           CC = `DUS_CLEAR_CYCLES;
    // power-down table: {pd, hz cfg, low power, high z, pulldown}
    logic [4:0]              rows [4] = '{5'h00, 5'h08, 5'h1e, 5'h15};

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // cycle count and count of dac load pulses
    always @(posedge clk) begin
        cc++;
        if (ld_all === 1'b1) lc++;
    end

    dus_host_model dus_host_model_inst (.clk(clk), .sclk(sclk), .sdi(sdi), .wr_n(wr_n),
        .cs_n(cs_n));

    dus_seq dus_seq_inst (.CLK(clk), .RST_B(rst_b), .RESET_PIN_B(rstp_b),
        .LOAD_OUTPUTS_N(ld_n), .CLEAR_TO_CODE_N(clr_n), .POWER_DOWN_IN(pd),
        .FIFO_EN_IN(fifo), .INTERFACE_SELECT(isel), .DATA_BIT_NINE(db9),
        .DATA_BIT_TEN(sclk), .DATA_BIT_ELEVEN_IN(sda), .WRITE_STROBE_N(wr_n),
        .CHIP_SELECT_N(cs_n), .PD_HIGH_Z_CFG(hz), .ACK_PULL(ack),
        .DATA_BIT_ELEVEN_OUT(sda_o), .DATA_BIT_ELEVEN_OE(sda_oe), .BUSY_N(busy_n),
        .HOST_IF_EN(if_en), .REG_WRITE(reg_wr), .DAC_LOAD_ALL(ld_all),
        .DAC_LOAD_CLEAR(ld_clr), .DEFAULTS_LOAD(dflt), .ANALOG_LOW_POWER(lowp),
        .OUT_HIGH_Z(hiz), .OUT_PULLDOWN(pdn), .SERIAL_MODE(ser), .I2C_MODE(i2c),
        .FIFO_ON(fifo_on), .SHIFT_WORD(sword));

    ////////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic test_done();
        $display("errors %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    // bounded wait for one monitored output to reach a level
    task automatic wt(input int b, input logic v, input int lim);
        n = 0;
        while (mon[b] !== v) begin
            if (n == lim) begin
                err_count++;
                $display("CHECK FAILED wait %0d expected %b seen timeout", b, v);
                test_done();
            end
            cyc(1);
            n++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_b, ack, pd, hz, db9, isel} = '0;
        {rstp_b, ld_n, clr_n, fifo} = '1;
        err_count = 0;
        tests_run = 0;
        cyc(4);
        chk("busy in por", 0, busy_n);
        @(posedge clk) rst_b <= 1'b1;
        t0 = cc;
        cyc(100);
        chk("if off por", 0, if_en);
        @(posedge clk) ld_n <= 1'b0;
        cyc(10);
        @(posedge clk) ld_n <= 1'b1;
        wt(4, 1, RC);
        chk("por len", 1, (cc - t0 > RC - 12) && (cc - t0 < RC + 12));
        cyc(60);
        chk("por busy", 1, busy_n);
        chk("por load", 0, lc);
        chk("fifo on", 3'b101, {fifo_on, ser, if_en});
        // power-down table
        foreach (rows[i]) begin
            @(posedge clk) {pd, hz} <= rows[i][4:3];
            cyc(6);
            chk("power down", rows[i][2:0], {lowp, hiz, pdn});
        end
        // load while idle; power-down, still on after the last table row, is switched off again
        @(posedge clk) {pd, ld_n} <= 2'b00;
        wt(1, 1, 20);
        cyc(40);
        chk("idle load", 1, lc);
        @(posedge clk) ld_n <= 1'b1;
        // load during a calculation is stored and run once busy ends
        k = lc;
        dus_host_model_inst.pwrite();
        wt(2, 1, 10);
        wt(0, 0, 6);
        @(posedge clk) ld_n <= 1'b0;
        dus_host_model_inst.pwrite();
        wt(2, 1, 8);
        chk("no early load", k, lc);
        wt(0, 1, 30);
        wt(1, 1, 40);
        cyc(40);
        chk("one load", k + 1, lc);
        @(posedge clk) ld_n <= 1'b1;
        // clear resamples the fifo strap
        @(posedge clk) begin
            fifo  <= 1'b0;
            clr_n <= 1'b0;
        end
        t0 = cc;
        wt(3, 1, CC + 40);
        chk("clear len", 1, (cc - t0 > CC - 12) && (cc - t0 < CC + 12));
        cyc(3);
        chk("clear end", 2'b10, {busy_n, fifo_on});
        @(posedge clk) clr_n <= 1'b1;
        // reset pin drops a stored load and ignores loads; serial straps
        // fifo strap low
        @(posedge clk) isel <= 1'b1;
        k = lc;
        dus_host_model_inst.pwrite();
        wt(0, 0, 12);
        @(posedge clk) ld_n <= 1'b0;
        @(posedge clk) rstp_b <= 1'b0;
        t0 = cc;
        cyc(30);
        chk("if off pin", 2'b00, {if_en, busy_n});
        @(posedge clk) ld_n <= 1'b1;
        cyc(10);
        @(posedge clk) ld_n <= 1'b0;
        wt(4, 1, RC + 40);
        chk("pin len", 1, (cc - t0 > RC - 12) && (cc - t0 < RC + 12));
        cyc(100);
        chk("pin level", 1, busy_n);
        chk("load dropped", k, lc);
        chk("spi mode", 4'b1001, {ser, i2c, fifo_on, if_en});
        @(posedge clk) begin
            rstp_b <= 1'b1;
            ld_n   <= 1'b1;
        end
        // spi words, the second one in power-down
        dus_host_model_inst.spi_word(24'ha5c396);
        cyc(4);
        chk("spi word", 24'ha5c396, sword);
        @(posedge clk) pd <= 1'b1;
        dus_host_model_inst.spi_word(24'h3c0f81);
        cyc(4);
        chk("spi in pd", 24'h3c0f81, sword);
        @(posedge clk) pd <= 1'b0;
        // i2c through a clear, then acknowledge on the open-drain line
        @(posedge clk) begin
            db9   <= 1'b1;
            clr_n <= 1'b0;
        end
        wt(3, 1, CC + 40);
        cyc(3);
        chk("i2c mode", 2'b11, {ser, i2c});
        @(posedge clk) begin
            clr_n <= 1'b1;
            ack   <= 1'b1;
        end
        dus_host_model_inst.bit_out(1'b1);
        cyc(1);
        chk("sda pulled", 2'b00, {sda, sda_o});
        @(posedge clk) ack <= 1'b0;
        dus_host_model_inst.bit_out(1'b1);
        cyc(1);
        chk("sda free", 2'b10, {sda, sda_oe});
        test_done();
    end
endmodule
